// ===== hdl/pcge_consts.svh
// Purpose: offsets, field positions, reset values and masks of the
//          peripheral clock gate enable block
// Assumes: 32-bit register words, byte addresses
// Notes:   included by bare name
`ifndef PCGE_CONSTS_SVH
`define PCGE_CONSTS_SVH

// register byte offsets
`define PCGE_FAST_OFS 8'h00
`define PCGE_SLOW_OFS 8'h04

// fast-bus enable register bit positions
`define PCGE_UART_EIGHT_CLK_ON 26
`define PCGE_UART_SEVEN_CLK_ON 25
`define PCGE_USART_SIX_CLK_ON 24
`define PCGE_I2C_THREE_CLK_ON 23
`define PCGE_AUTO_CALIB_CLK_ON 22
`define PCGE_TIMER_ELEVEN_CLK_ON 21
`define PCGE_TIMER_TEN_CLK_ON 20
`define PCGE_TIMER_NINE_CLK_ON 19
`define PCGE_CONVERTER_THREE_CLK_ON 15
`define PCGE_USART_ONE_CLK_ON 14
`define PCGE_TIMER_EIGHT_CLK_ON 13
`define PCGE_SPI_ONE_CLK_ON 12
`define PCGE_TIMER_ONE_CLK_ON 11
`define PCGE_CONVERTER_TWO_CLK_ON 10
`define PCGE_CONVERTER_ONE_CLK_ON 9
`define PCGE_PORT_E_CLK_ON 6
`define PCGE_PORT_D_CLK_ON 5
`define PCGE_PORT_C_CLK_ON 4
`define PCGE_PORT_B_CLK_ON 3
`define PCGE_PORT_A_CLK_ON 2
`define PCGE_PIN_REMAP_CLK_ON 0

// slow-bus enable register bit positions
`define PCGE_DAC_CLK_ON 29
`define PCGE_POWER_CTL_CLK_ON 28
`define PCGE_BACKUP_REGS_CLK_ON 27
`define PCGE_CAN_TWO_CLK_ON 26
`define PCGE_CAN_ONE_CLK_ON 25
`define PCGE_USB_CLK_ON 23
`define PCGE_I2C_TWO_CLK_ON 22
`define PCGE_I2C_ONE_CLK_ON 21
`define PCGE_UART_FIVE_CLK_ON 20
`define PCGE_UART_FOUR_CLK_ON 19
`define PCGE_USART_THREE_CLK_ON 18
`define PCGE_USART_TWO_CLK_ON 17
`define PCGE_SPI_FOUR_CLK_ON 16
`define PCGE_SPI_THREE_CLK_ON 15
`define PCGE_SPI_TWO_CLK_ON 14
`define PCGE_WINDOW_WATCHDOG_CLK_ON 11

// storable bits; reserved read-only bits are absent and read zero
`define PCGE_FAST_WR_MASK 32'h07F8FFFF
`define PCGE_SLOW_WR_MASK 32'h3EFFC9FF
// bits 8:7 and 1 of the fast register store but gate nothing
`define PCGE_FAST_GATE_MASK 32'h07F8FE7D
`define PCGE_SLOW_GATE_MASK 32'h3EFFC9FF

// reset values: every clock off
`define PCGE_FAST_RST 32'h00000000
`define PCGE_SLOW_RST 32'h00000000

// bus answer codes
`define PCGE_RESP_OKAY 2'b00
`define PCGE_RESP_SLVERR 2'b10

`endif

// ===== hdl/pcge_pkg.sv
// Purpose: types of the peripheral clock gate enable block
// Assumes: nothing beyond the constants header
// Notes:   struct carries both enable words together
`default_nettype none
package pcge_pkg;
	typedef logic [31:0] pcge_word_t;

	// both enable registers, carried as one unit
	typedef struct packed {
		pcge_word_t fast_bus_periph_clock_enable;
		pcge_word_t slow_bus_periph_clock_enable;
	} pcge_regs_s;

	// read channel state, one-hot
	typedef enum logic [1:0] {
		PCGE_RD_IDLE = 2'b01,
		PCGE_RD_RESP = 2'b10
	} pcge_rd_e;
endpackage
`default_nettype wire

// ===== hdl/pcge_clk_gate.sv
// Purpose: glitch-free gating of a bank of clocks from enable levels
// Assumes: enables change only just after a rising clock edge
// Notes:   enable retimed on the falling edge, so the and-gate only
//          switches while the clock is low
`default_nettype none
module pcge_clk_gate #(
	parameter int WIDTH = 32
) (
	input wire logic clk_i, // clock to gate
	input wire logic rst_n_i, // async reset, active low
	input wire logic [WIDTH-1:0] en_i, // enable levels
	output logic [WIDTH-1:0] gclk_o // gated clocks
);
	logic [WIDTH-1:0] en_lo_d;
	logic [WIDTH-1:0] en_lo_q;

	// refused at elaboration: an empty gate bank serves nothing
	if (WIDTH < 1)
	begin
		$error("pcge_clk_gate: WIDTH must be at least 1");
	end

	// enable taken only at the falling clock edge
	always_comb
	begin
		en_lo_d = en_i;
	end

	// falling-edge retime avoids runt high pulses
	always_ff @(negedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			en_lo_q <= '0;
		end
		else
		begin
			en_lo_q <= en_lo_d;
		end
	end

	// whole pulses only: enable is stable while clock is high
	assign gclk_o = {WIDTH{clk_i}} & en_lo_q;
endmodule
`default_nettype wire

// ===== hdl/pcge_top.sv
// Purpose: fast- and slow-bus peripheral clock enable registers with
//          glitch-free gating of the peripheral clocks
// Assumes: AXI4-Lite master, one write and one read under way at most
// Notes:   enable levels and gated clocks both leave the block
//
// Operation
// - fast 26,25,24,23,14,12 gate uart8, uart7, usart6, i2c3, usart1, spi1
// - fast 22,21,20,19,13,11 gate calibration unit, timers 11,10,9,8,1
// - fast 15,10,9 gate converters; 6..2 ports E..A; 0 pin remap
// - slow 29,28,27,26,25,23 gate dac, power, backup, can2, can1, usb
// - slow 22 down to 17 gate i2c2, i2c1, uart5, uart4, usart3, usart2
// - slow bits 16,15,14 gate spi4..2; bit 11 gates window watchdog
// - reserved fields reset to zero; software leaves them there
// - slow bit 24 reserved: resets to zero, software leaves it
`include "pcge_consts.svh"
`default_nettype none
module pcge_top #(
	parameter int ADDR_W = 8
) (
	input wire logic MCLK_I, // system clock, 125 MHz
	input wire logic RST_N_I, // async reset, active low
	input wire logic [ADDR_W-1:0] AWADDR_I, // write address
	input wire logic [2:0] AWPROT_I, // write protection, unused
	input wire logic AWVALID_I, // write address valid
	output logic AWREADY_O, // write address ready
	input wire logic [31:0] WDATA_I, // write data
	input wire logic [3:0] WSTRB_I, // write byte enables
	input wire logic WVALID_I, // write data valid
	output logic WREADY_O, // write data ready
	output logic [1:0] BRESP_O, // write response
	output logic BVALID_O, // write response valid
	input wire logic BREADY_I, // write response ready
	input wire logic [ADDR_W-1:0] ARADDR_I, // read address
	input wire logic [2:0] ARPROT_I, // read protection, unused
	input wire logic ARVALID_I, // read address valid
	output logic ARREADY_O, // read address ready
	output logic [31:0] RDATA_O, // read data
	output logic [1:0] RRESP_O, // read response
	output logic RVALID_O, // read data valid
	input wire logic RREADY_I, // read data ready
	output pcge_pkg::pcge_word_t FAST_EN_O, // fast-bus enable levels
	output pcge_pkg::pcge_word_t SLOW_EN_O, // slow-bus enable levels
	output logic [31:0] FAST_GCLK_O, // fast-bus gated clocks
	output logic [31:0] SLOW_GCLK_O // slow-bus gated clocks
);
	import pcge_pkg::*;

	// register state
	pcge_regs_s regs_d;
	pcge_regs_s regs_q;

	// write channel state
	logic aw_got_d;
	logic aw_got_q;
	logic w_got_d;
	logic w_got_q;
	logic [ADDR_W-1:0] awaddr_d;
	logic [ADDR_W-1:0] awaddr_q;
	logic [31:0] wdata_d;
	logic [31:0] wdata_q;
	logic [3:0] wstrb_d;
	logic [3:0] wstrb_q;
	logic awready_d;
	logic awready_q;
	logic wready_d;
	logic wready_q;
	logic bvalid_d;
	logic bvalid_q;
	logic [1:0] bresp_d;
	logic [1:0] bresp_q;

	// read channel state
	pcge_rd_e rd_st_d;
	pcge_rd_e rd_st_q;
	logic arready_d;
	logic arready_q;
	logic rvalid_d;
	logic rvalid_q;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	logic [1:0] rresp_d;
	logic [1:0] rresp_q;

	// gate enables, masked to real peripheral bits
	logic [31:0] fast_gate;
	logic [31:0] slow_gate;

	// handshake and decode terms
	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_write;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [31:0] byte_mask;

	if (ADDR_W < 3 || ADDR_W > 32)
	begin
		$error("pcge_top: ADDR_W must lie between 3 and 32");
	end

	// expand byte enables to a bit mask
	function automatic logic [31:0] strb_to_mask(input logic [3:0] s);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < 4; i++)
		begin
			m[i*8 +: 8] = {8{s[i]}};
		end
		return m;
	endfunction

	// merge a write into a word, keeping unstored bits at zero
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [31:0] bm,
		input logic [31:0] wm);
		logic [31:0] r;
		r = ((old & ~bm) | (data & bm)) & wm;
		return r;
	endfunction

	// handshakes happen when valid meets a registered ready
	assign aw_hs = AWVALID_I & awready_q;
	assign w_hs = WVALID_I & wready_q;
	assign ar_hs = ARVALID_I & arready_q;

	// use the held beat, or the one arriving this cycle
	assign wr_addr = aw_hs ? AWADDR_I : awaddr_q;
	assign wr_data = w_hs ? WDATA_I : wdata_q;
	assign wr_strb = w_hs ? WSTRB_I : wstrb_q;
	assign byte_mask = strb_to_mask(wr_strb);
	assign do_write = (aw_got_q | aw_hs) & (w_got_q | w_hs) & ~bvalid_q;

	// write channel: address and data in either order, then response
	always_comb
	begin
		aw_got_d = aw_got_q | aw_hs;
		w_got_d = w_got_q | w_hs;
		awaddr_d = aw_hs ? AWADDR_I : awaddr_q;
		wdata_d = w_hs ? WDATA_I : wdata_q;
		wstrb_d = w_hs ? WSTRB_I : wstrb_q;
		bvalid_d = bvalid_q & ~BREADY_I;
		bresp_d = bresp_q;
		regs_d = regs_q;
		if (do_write)
		begin
			aw_got_d = 1'b0;
			w_got_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = `PCGE_RESP_OKAY;
			// reserved read-only bits never store; they stay zero
			case (wr_addr[ADDR_W-1:2])
				`PCGE_FAST_OFS >> 2:
				begin
					regs_d.fast_bus_periph_clock_enable = merge(
						regs_q.fast_bus_periph_clock_enable, wr_data,
						byte_mask, `PCGE_FAST_WR_MASK);
				end
				`PCGE_SLOW_OFS >> 2:
				begin
					regs_d.slow_bus_periph_clock_enable = merge(
						regs_q.slow_bus_periph_clock_enable, wr_data,
						byte_mask, `PCGE_SLOW_WR_MASK);
				end
				default:
				begin
					bresp_d = `PCGE_RESP_SLVERR;
				end
			endcase
		end
		// one write at a time: no new beats while a response waits
		awready_d = ~aw_got_d & ~bvalid_d;
		wready_d = ~w_got_d & ~bvalid_d;
	end

	// read channel: one read under way, answer one cycle after address
	always_comb
	begin
		rd_st_d = rd_st_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		case (rd_st_q)
			PCGE_RD_IDLE:
			begin
				if (ar_hs)
				begin
					rd_st_d = PCGE_RD_RESP;
					rvalid_d = 1'b1;
					rresp_d = `PCGE_RESP_OKAY;
					case (ARADDR_I[ADDR_W-1:2])
						`PCGE_FAST_OFS >> 2:
						begin
							rdata_d = regs_q.fast_bus_periph_clock_enable;
						end
						`PCGE_SLOW_OFS >> 2:
						begin
							rdata_d = regs_q.slow_bus_periph_clock_enable;
						end
						default:
						begin
							rdata_d = 32'h00000000;
							rresp_d = `PCGE_RESP_SLVERR;
						end
					endcase
				end
			end
			PCGE_RD_RESP:
			begin
				if (RREADY_I)
				begin
					rd_st_d = PCGE_RD_IDLE;
					rvalid_d = 1'b0;
				end
			end
			default:
			begin
				rd_st_d = PCGE_RD_IDLE;
				rvalid_d = 1'b0;
			end
		endcase
		arready_d = (rd_st_d == PCGE_RD_IDLE);
	end

	// bus and register state; every enable starts off
	always_ff @(posedge MCLK_I or negedge RST_N_I)
	begin
		if (!RST_N_I)
		begin
			regs_q.fast_bus_periph_clock_enable <= `PCGE_FAST_RST;
			regs_q.slow_bus_periph_clock_enable <= `PCGE_SLOW_RST;
			aw_got_q <= 1'b0;
			w_got_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			bvalid_q <= 1'b0;
			bresp_q <= `PCGE_RESP_OKAY;
			rd_st_q <= PCGE_RD_IDLE;
			arready_q <= 1'b0;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= `PCGE_RESP_OKAY;
		end
		else
		begin
			regs_q <= regs_d;
			aw_got_q <= aw_got_d;
			w_got_q <= w_got_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			rd_st_q <= rd_st_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// route each stored enable to its peripheral clock gate
	always_comb
	begin
		fast_gate = 32'h00000000;
		slow_gate = 32'h00000000;
		fast_gate[`PCGE_UART_EIGHT_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_UART_EIGHT_CLK_ON];
		fast_gate[`PCGE_UART_SEVEN_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_UART_SEVEN_CLK_ON];
		fast_gate[`PCGE_USART_SIX_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_USART_SIX_CLK_ON];
		fast_gate[`PCGE_I2C_THREE_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_I2C_THREE_CLK_ON];
		fast_gate[`PCGE_USART_ONE_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_USART_ONE_CLK_ON];
		fast_gate[`PCGE_SPI_ONE_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_SPI_ONE_CLK_ON];
		// calibration unit and the fast-bus timers
		fast_gate[22:19] = regs_q.fast_bus_periph_clock_enable[22:19];
		fast_gate[`PCGE_TIMER_EIGHT_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_TIMER_EIGHT_CLK_ON];
		fast_gate[`PCGE_TIMER_ONE_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_TIMER_ONE_CLK_ON];
		// converters, ports and pin remap
		fast_gate[`PCGE_CONVERTER_THREE_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_CONVERTER_THREE_CLK_ON];
		fast_gate[10:9] = regs_q.fast_bus_periph_clock_enable[10:9];
		fast_gate[6:2] = regs_q.fast_bus_periph_clock_enable[6:2];
		fast_gate[`PCGE_PIN_REMAP_CLK_ON] =
			regs_q.fast_bus_periph_clock_enable[`PCGE_PIN_REMAP_CLK_ON];
		// slow-bus peripherals
		slow_gate[29:25] = regs_q.slow_bus_periph_clock_enable[29:25];
		slow_gate[`PCGE_USB_CLK_ON] =
			regs_q.slow_bus_periph_clock_enable[`PCGE_USB_CLK_ON];
		slow_gate[22:17] = regs_q.slow_bus_periph_clock_enable[22:17];
		slow_gate[16:14] = regs_q.slow_bus_periph_clock_enable[16:14];
		slow_gate[`PCGE_WINDOW_WATCHDOG_CLK_ON] =
			regs_q.slow_bus_periph_clock_enable[11];
		// low slow bits are stored enables for the remaining timers
		slow_gate[8:0] = regs_q.slow_bus_periph_clock_enable[8:0];
	end

	// gates retime on the falling edge so pulses are never cut short
	pcge_clk_gate #(.WIDTH(32)) u_fast_gate (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.en_i(fast_gate & `PCGE_FAST_GATE_MASK),
		.gclk_o(FAST_GCLK_O)
	);
	pcge_clk_gate #(.WIDTH(32)) u_slow_gate (
		.clk_i(MCLK_I),
		.rst_n_i(RST_N_I),
		.en_i(slow_gate & `PCGE_SLOW_GATE_MASK),
		.gclk_o(SLOW_GCLK_O)
	);

	// outputs straight from flip-flops
	assign AWREADY_O = awready_q;
	assign WREADY_O = wready_q;
	assign BVALID_O = bvalid_q;
	assign BRESP_O = bresp_q;
	assign ARREADY_O = arready_q;
	assign RVALID_O = rvalid_q;
	assign RDATA_O = rdata_q;
	assign RRESP_O = rresp_q;
	assign FAST_EN_O = regs_q.fast_bus_periph_clock_enable;
	assign SLOW_EN_O = regs_q.slow_bus_periph_clock_enable;
endmodule
`default_nettype wire

// ===== dv/pcge_assertions.sv
// Purpose: port checks of the clock gate enable block
// Assumes: bound to pcge_top, enables move only on a write answer
// Notes:   gated clocks are judged on the falling edge, while high
`include "pcge_consts.svh"
`default_nettype none
module pcge_assertions (
	input wire logic MCLK_I, // system clock
	input wire logic RST_N_I, // async reset, active low
	input wire logic ARVALID_I, // read address valid
	input wire logic ARREADY_O, // read address ready
	input wire logic AWREADY_O, // write address ready
	input wire logic WREADY_O, // write data ready
	input wire logic BVALID_O, // write response valid
	input wire logic BREADY_I, // write response ready
	input wire logic [1:0] BRESP_O, // write response
	input wire logic [31:0] RDATA_O, // read data
	input wire logic RVALID_O, // read data valid
	input wire logic RREADY_I, // read data ready
	input wire pcge_pkg::pcge_word_t FAST_EN_O, // fast enables
	input wire pcge_pkg::pcge_word_t SLOW_EN_O, // slow enables
	input wire logic [31:0] FAST_GCLK_O, // fast gated clocks
	input wire logic [31:0] SLOW_GCLK_O // slow gated clocks
);
	timeunit 1ns;
	timeprecision 1ps;
	import pcge_pkg::*;
	// all checks share the system clock and its reset
	default clocking @(posedge MCLK_I); endclocking
	default disable iff (!RST_N_I);

	rsvd_fast_zero_a: assert property (
		FAST_EN_O[31:27] == 5'h00 && FAST_EN_O[18:16] == 3'h0)
		else $error("fast reserved bit set");
	rsvd_slow_zero_a: assert property (
		SLOW_EN_O[31:30] == 2'h0 && SLOW_EN_O[13:12] == 2'h0)
		else $error("slow reserved bit set");
	slow_bit24_a: assert property (SLOW_EN_O[24] == 1'b0)
		else $error("slow bit 24 set");
	// high phase only: a runt would show as a mismatch here
	gclk_fast_a: assert property (@(negedge MCLK_I)
		FAST_GCLK_O == ($past(FAST_EN_O) & `PCGE_FAST_GATE_MASK))
		else $error("fast gated clock wrong");
	gclk_slow_a: assert property (@(negedge MCLK_I)
		SLOW_GCLK_O == ($past(SLOW_EN_O) & `PCGE_SLOW_GATE_MASK))
		else $error("slow gated clock wrong");
	en_hold_a: assert property (!$rose(BVALID_O) |->
		$stable(FAST_EN_O) && $stable(SLOW_EN_O))
		else $error("enable moved without a write");
	bvalid_hold_a: assert property (BVALID_O && !BREADY_I |=>
		BVALID_O && $stable(BRESP_O))
		else $error("write answer dropped early");
	// no second write may start while an answer is pending
	wr_busy_a: assert property (BVALID_O |->
		!AWREADY_O && !WREADY_O)
		else $error("write beat accepted during answer");
	rd_answer_a: assert property (ARVALID_I && ARREADY_O |=>
		RVALID_O && !ARREADY_O)
		else $error("read answer late");
	rvalid_hold_a: assert property (RVALID_O && !RREADY_I |=>
		RVALID_O && $stable(RDATA_O))
		else $error("read answer dropped early");
endmodule
bind pcge_top pcge_assertions i_chk (.MCLK_I(MCLK_I), .RST_N_I(RST_N_I),
	.ARVALID_I(ARVALID_I), .ARREADY_O(ARREADY_O), .AWREADY_O(AWREADY_O),
	.WREADY_O(WREADY_O), .BVALID_O(BVALID_O),
	.BREADY_I(BREADY_I), .BRESP_O(BRESP_O), .RDATA_O(RDATA_O),
	.RVALID_O(RVALID_O), .RREADY_I(RREADY_I), .FAST_EN_O(FAST_EN_O),
	.SLOW_EN_O(SLOW_EN_O), .FAST_GCLK_O(FAST_GCLK_O),
	.SLOW_GCLK_O(SLOW_GCLK_O));
`default_nettype wire

// ===== dv/pcge_top_tb.sv
// Purpose: self-checking bench of the clock gate enable block
// Assumes: AXI4-Lite slave, answers awaited under a global timeout
// Notes:   bus outputs sampled on falling edges, inputs driven on rising
`include "pcge_consts.svh"
`default_nettype none
module pcge_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import pcge_pkg::*;
	logic clk, rst_n, awv, wv, bready, arv, rready;
	logic awrdy, wrdy, bvalid, arrdy, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, fgclk, sgclk;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	pcge_word_t fen, sen;
	int mismatches, checks_done, cycles;

	pcge_top i_dut (.MCLK_I(clk), .RST_N_I(rst_n), .AWADDR_I(awaddr),
		.AWPROT_I(3'h0), .AWVALID_I(awv), .AWREADY_O(awrdy),
		.WDATA_I(wdata), .WSTRB_I(wstrb), .WVALID_I(wv), .WREADY_O(wrdy),
		.BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready),
		.ARADDR_I(araddr), .ARPROT_I(3'h0), .ARVALID_I(arv),
		.ARREADY_O(arrdy), .RDATA_O(rdata), .RRESP_O(rresp),
		.RVALID_O(rvalid), .RREADY_I(rready), .FAST_EN_O(fen),
		.SLOW_EN_O(sen), .FAST_GCLK_O(fgclk), .SLOW_GCLK_O(sgclk));

	// 125 MHz system clock
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("FAIL at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one write; lag holds bready off for a while to test the hold
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er, input int lag);
		logic ta, tw, tb;
		int k;
		@(posedge clk);
		tb = 1'b0;
		k = 0;
		awaddr <= a;
		wdata <= d;
		wstrb <= s;
		awv <= 1'b1;
		wv <= 1'b1;
		bready <= (lag == 0);
		while (!tb)
		begin
			@(negedge clk);
			ta = awv && awrdy;
			tw = wv && wrdy;
			tb = bready && bvalid;
			if (tb)
				chk(32'(bresp), 32'(er));
			@(posedge clk);
			awv <= awv && !ta;
			wv <= wv && !tw;
			bready <= (bready && !tb) || (k == lag);
			k++;
		end
	endtask

	// one read, judged on the falling edge of the handshake cycle
	task automatic rd(input logic [7:0] a, input logic [31:0] ed,
		input logic [1:0] er, input int lag);
		logic ta, tr;
		int k;
		@(posedge clk);
		tr = 1'b0;
		k = 0;
		araddr <= a;
		arv <= 1'b1;
		rready <= (lag == 0);
		while (!tr)
		begin
			@(negedge clk);
			ta = arv && arrdy;
			tr = rready && rvalid;
			if (tr)
			begin
				chk(rdata, ed);
				chk(32'(rresp), 32'(er));
			end
			@(posedge clk);
			arv <= arv && !ta;
			rready <= (rready && !tr) || (k == lag);
			k++;
		end
	endtask

	// one enable group: store, read back, clocks run only while high
	task automatic t_field(input logic [7:0] a, input logic [31:0] m);
		wr(a, m, 4'hF, `PCGE_RESP_OKAY, 0);
		rd(a, m, `PCGE_RESP_OKAY, 0);
		@(posedge clk);
		#2;
		chk(a == `PCGE_FAST_OFS ? fgclk : sgclk, m);
		chk(a == `PCGE_FAST_OFS ? fen : sen, m);
		@(negedge clk);
		#2;
		chk(a == `PCGE_FAST_OFS ? fgclk : sgclk, 32'h0);
	endtask

	// reserved bits, slow answers and a partial strobe
	task automatic t_reserved();
		// software side keeps reserved bits and fast bit 1 at zero
		wr(`PCGE_FAST_OFS, `PCGE_FAST_WR_MASK & 32'hFFFFFFFD, 4'hF,
			`PCGE_RESP_OKAY, 2);
		rd(`PCGE_FAST_OFS, `PCGE_FAST_WR_MASK & 32'hFFFFFFFD,
			`PCGE_RESP_OKAY, 3);
		wr(`PCGE_SLOW_OFS, `PCGE_SLOW_WR_MASK, 4'hF, `PCGE_RESP_OKAY, 0);
		rd(`PCGE_SLOW_OFS, `PCGE_SLOW_WR_MASK, `PCGE_RESP_OKAY, 0);
		wr(`PCGE_FAST_OFS, 32'h0, 4'h2, `PCGE_RESP_OKAY, 0);
		@(negedge clk);
		chk(fen, `PCGE_FAST_WR_MASK & 32'hFFFF00FD);
		chk(sen, `PCGE_SLOW_WR_MASK);
	endtask

	// unmapped words refuse and leave the registers alone
	task automatic t_unmapped();
		wr(8'h08, 32'h0, 4'hF, `PCGE_RESP_SLVERR, 0);
		rd(8'hFC, 32'h0, `PCGE_RESP_SLVERR, 1);
		@(negedge clk);
		chk(sen, `PCGE_SLOW_WR_MASK);
		chk(fen, `PCGE_FAST_WR_MASK & 32'hFFFF00FD);
	endtask

	// reset in mid-run turns every clock off
	task automatic t_midreset();
		@(posedge clk);
		rst_n <= 1'b0;
		@(negedge clk);
		chk(fen, `PCGE_FAST_RST);
		chk(sen, `PCGE_SLOW_RST);
		@(posedge clk);
		rst_n <= 1'b1;
		rd(`PCGE_SLOW_OFS, `PCGE_SLOW_RST, `PCGE_RESP_OKAY, 0);
	endtask

	// hang guard
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 4000)
		begin
			mismatches++;
			end_of_test();
		end
	end

	// main sequence
	initial
	begin
		{rst_n, awv, wv, bready, arv, rready} = 6'h00;
		{awaddr, araddr, wdata, wstrb} = 52'h0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		rd(`PCGE_FAST_OFS, `PCGE_FAST_RST, `PCGE_RESP_OKAY, 0);
		t_field(`PCGE_FAST_OFS, 32'h07805000);
		t_field(`PCGE_FAST_OFS, 32'h00782800);
		t_field(`PCGE_FAST_OFS, 32'h0000867D);
		t_field(`PCGE_SLOW_OFS, 32'h3E800000);
		t_field(`PCGE_SLOW_OFS, 32'h007E0000);
		t_field(`PCGE_SLOW_OFS, 32'h0001C800);
		t_reserved();
		t_unmapped();
		t_midreset();
		end_of_test();
	end
endmodule
`default_nettype wire
